// ### core/pmc_top.sv
// Power-mode and system clock control with an AXI4-Lite register slave.
// Assumes the CPU pulses instr_done at each instruction end and irq_taken on vectoring.
// Oscillator and wake pins come from outside the clock domain.
// Function
// - Idle request stops CPU after instruction
// - Idle keeps peripheral clocks running
// - Interrupt ends idle, clears request bit
// - Non-software reset ends idle
// - Power-down stops whole clock system
// - Power-down request is last instruction
// - RAM and port latches held
// - Non-software reset ends power-down
// - Pin or power-on reset restarts CPU from power-down
// - Enabled external pin wakes power-down
// - Brown-out, watchdog, keypad also wake
// - Keypad wakes on opposite edge only
// - Select field picks RC or crystal
// - RC fast bit bypasses divide-by-two
// - Filter bit filters crystal input
// - Configuration resets to all ones
// - System divider ratio from register
// - Both requests give power-down only
// - Watchdog cleared entering and waking
`timescale 1ns/10ps
`default_nettype none
module pmc_top #(
   parameter int DIV_W = 8
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [pmc_pkg::PMC_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [pmc_pkg::PMC_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic soft_reset,
   input wire logic por_reset,
   input wire logic pin_reset,
   input wire logic bod_reset,
   input wire logic wdt_reset,
   input wire logic instr_done,
   input wire logic irq_taken,
   input wire logic irq_pending,
   input wire logic rc_osc_pin,
   input wire logic crystal_input_pin,
   input wire logic [1:0] ext_int_pin,
   input wire logic bod_event,
   input wire logic wdt_event,
   input wire logic keypad_pin,
   output pmc_pkg::pmc_ctrl_t ctrl,
   output pmc_pkg::pmc_clk_sel_t clk_sel,
   output logic sys_tick,
   output logic cpu_restart
);
   import pmc_pkg::*;

   // Synchronisers for off-domain inputs
   logic [1:0] rc_s, xt_s, kp_s;
   logic [1:0] e0_s, e1_s;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rc_s <= '0;
         xt_s <= '0;
         kp_s <= '0;
         e0_s <= '0;
         e1_s <= '0;
      end else begin
         rc_s <= {rc_s[0], rc_osc_pin};
         xt_s <= {xt_s[0], crystal_input_pin};
         kp_s <= {kp_s[0], keypad_pin};
         e0_s <= {e0_s[0], ext_int_pin[0]};
         e1_s <= {e1_s[0], ext_int_pin[1]};
      end
   end

   // Registers
   logic [7:0] clock_config_byte;
   logic [DIV_W-1:0] system_clock_divider;
   logic idle_request_bit, powerdown_request_bit;
   logic global_interrupt_enable;
   logic [PMC_WAKE_W-1:0] wake_en;
   pmc_mode_t mode;
   // Keypad level captured at power-down entry
   logic kp_level;

   // AXI4-Lite slave
   logic [PMC_ADDR_W-1:0] aw_q;
   logic aw_have, w_have;
   logic [31:0] w_q;
   logic [3:0] ws_q;
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire wr_fire = aw_have & w_have & ~s_axi_bvalid;
   wire sel_pwr = wr_fire & (aw_q == PMC_OFF_PWR_CTRL) & ws_q[0];
   wire sel_cfg = wr_fire & (aw_q == PMC_OFF_CLK_CFG) & ws_q[0];
   wire sel_div = wr_fire & (aw_q == PMC_OFF_SYS_DIV) & ws_q[0];
   wire sel_wen = wr_fire & (aw_q == PMC_OFF_WAKE_EN) & ws_q[0];
   wire wr_ok = (aw_q == PMC_OFF_PWR_CTRL) | (aw_q == PMC_OFF_CLK_CFG) |
      (aw_q == PMC_OFF_SYS_DIV) | (aw_q == PMC_OFF_WAKE_EN) | (aw_q == PMC_OFF_STATUS);
   wire rd_fire = s_axi_arvalid & s_axi_arready;
   wire [31:0] rd_pwr = {30'h0, powerdown_request_bit, idle_request_bit};
   wire [31:0] rd_cfg = {24'h0, clock_config_byte};
   wire [31:0] rd_div = {24'h0, system_clock_divider};
   wire [31:0] rd_wen = {24'h0, global_interrupt_enable, 2'h0, wake_en};
   wire [31:0] rd_sta = {29'h0, mode == PMC_PDOWN, mode == PMC_IDLE, kp_level};
   wire rd_hit = (s_axi_araddr == PMC_OFF_PWR_CTRL) | (s_axi_araddr == PMC_OFF_CLK_CFG) |
      (s_axi_araddr == PMC_OFF_SYS_DIV) | (s_axi_araddr == PMC_OFF_WAKE_EN) |
      (s_axi_araddr == PMC_OFF_STATUS);
   wire [31:0] rd_mux = (s_axi_araddr == PMC_OFF_PWR_CTRL) ? rd_pwr :
      (s_axi_araddr == PMC_OFF_CLK_CFG) ? rd_cfg :
      (s_axi_araddr == PMC_OFF_SYS_DIV) ? rd_div :
      (s_axi_araddr == PMC_OFF_WAKE_EN) ? rd_wen :
      (s_axi_araddr == PMC_OFF_STATUS) ? rd_sta : 32'h0;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         aw_have <= 1'b0;
         w_have <= 1'b0;
         aw_q <= '0;
         w_q <= '0;
         ws_q <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= PMC_RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_have <= 1'b1;
            aw_q <= s_axi_awaddr;
         end
         if (w_take) begin
            w_have <= 1'b1;
            w_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? PMC_RESP_OKAY : PMC_RESP_SLVERR;
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   assign s_axi_awready = ~aw_have;
   assign s_axi_wready = ~w_have;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= PMC_RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= rd_hit ? PMC_RESP_OKAY : PMC_RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
   assign s_axi_arready = ~s_axi_rvalid;

   logic e0_d, e1_d, kp_d;
   wire e0_fall = e0_d & ~e0_s[1];
   wire e1_fall = e1_d & ~e1_s[1];
   wire kp_wake = (kp_level ? (kp_d & ~kp_s[1]) : (~kp_d & kp_s[1]));
   // external pin needs its enable and global enable
   // wake built from pin events, not system ticks
   wire [PMC_WAKE_W-1:0] wake_src = {kp_wake, wdt_event, bod_event, e1_fall, e0_fall};
   wire wake_any = global_interrupt_enable & |(wake_src & wake_en);
   // Reset sources other than software reset
   // reset ends idle
   wire hard_reset = por_reset | pin_reset | bod_reset | wdt_reset;

   // Requests are armed by software and taken at the end of the writing instruction
   logic req_pend;
   wire enter = req_pend & instr_done;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         e0_d <= 1'b0;
         e1_d <= 1'b0;
         kp_d <= 1'b0;
      end else begin
         e0_d <= e0_s[1];
         e1_d <= e1_s[1];
         kp_d <= kp_s[1];
      end
   end

   // Mode state machine
   pmc_mode_t next_mode;
   always_comb begin
      next_mode = mode;
      case (mode)
         PMC_RUN: begin
            if (enter & powerdown_request_bit) begin
               next_mode = PMC_PDOWN;
            end else if (enter & idle_request_bit) begin
               next_mode = PMC_IDLE;
            end
         end
         PMC_IDLE: begin
            if (hard_reset | (irq_pending & global_interrupt_enable)) begin
               next_mode = PMC_RUN;
            end
         end
         PMC_PDOWN: begin
            // wake returns to run, never to idle
            if (hard_reset | wake_any) begin
               next_mode = PMC_RUN;
            end
         end
         default: next_mode = PMC_RUN;
      endcase
   end

   wire leaving = (mode != PMC_RUN) & (next_mode == PMC_RUN);
   wire entering = (mode == PMC_RUN) & (next_mode != PMC_RUN);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mode <= PMC_RUN;
         idle_request_bit <= 1'b0;
         powerdown_request_bit <= 1'b0;
         req_pend <= 1'b0;
         kp_level <= 1'b0;
         cpu_restart <= 1'b0;
      end else begin
         mode <= next_mode;
         cpu_restart <= 1'b0;
         if (mode == PMC_PDOWN && (por_reset | pin_reset)) begin
            cpu_restart <= 1'b1;
         end
         if (entering & next_mode == PMC_PDOWN) begin
            kp_level <= kp_s[1];
         end
         if (enter) begin
            req_pend <= 1'b0;
         end
         if (sel_pwr) begin
            idle_request_bit <= w_q[PMC_BIT_IDLE];
            powerdown_request_bit <= w_q[PMC_BIT_PDOWN];
            req_pend <= w_q[PMC_BIT_IDLE] | w_q[PMC_BIT_PDOWN];
         end
         if (leaving) begin
            idle_request_bit <= 1'b0;
            powerdown_request_bit <= 1'b0;
         end
      end
   end

   // Configuration and divider registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         clock_config_byte <= PMC_CLK_CFG_RESET;
         system_clock_divider <= PMC_SYS_DIV_RESET[DIV_W-1:0];
         wake_en <= '0;
         global_interrupt_enable <= 1'b0;
      end else begin
         if (sel_cfg) begin
            clock_config_byte <= (w_q[7:0] & PMC_CLK_CFG_MASK) | ~PMC_CLK_CFG_MASK;
         end
         if (sel_div) begin
            system_clock_divider <= w_q[DIV_W-1:0];
         end
         if (sel_wen) begin
            wake_en <= w_q[PMC_WAKE_W-1:0];
            global_interrupt_enable <= w_q[7];
         end
      end
   end

   // Clock source selection
   wire [1:0] osc_sel = clock_config_byte[PMC_FLD_OSC_LO +: 2];
   wire rc_fast = clock_config_byte[PMC_FLD_RCFS];
   wire filt_en = clock_config_byte[PMC_FLD_CKF];
   wire use_rc = (osc_sel == PMC_OSC_RC);
   // remaining codes use the crystal pin as a clock input
   wire use_xtal_pin = ~use_rc;

   logic [PMC_FILT_LEN-1:0] xt_hist;
   logic xt_filt;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         xt_hist <= '0;
         xt_filt <= 1'b0;
      end else begin
         xt_hist <= {xt_hist[PMC_FILT_LEN-2:0], xt_s[1]};
         if (&xt_hist) begin
            xt_filt <= 1'b1;
         end else if (~|xt_hist) begin
            xt_filt <= 1'b0;
         end
      end
   end
   wire xt_lvl = filt_en ? xt_filt : xt_s[1];

   // Rising edges of the chosen oscillator, with RC half-rate toggle
   logic rc_d, xt_d, rc_half;
   wire rc_edge = rc_s[1] & ~rc_d;
   wire xt_edge = xt_lvl & ~xt_d;
   wire rc_tick = rc_edge & (rc_fast | rc_half);
   wire osc_tick = (mode != PMC_PDOWN) & (use_rc ? rc_tick : (use_xtal_pin & xt_edge));
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rc_d <= 1'b0;
         xt_d <= 1'b0;
         rc_half <= 1'b0;
      end else begin
         rc_d <= rc_s[1];
         xt_d <= xt_lvl;
         if (rc_edge) begin
            rc_half <= ~rc_half;
         end
      end
   end

   pmc_clkdiv #(.DIV_W(DIV_W)) u_div (
      .clk(clk),
      .resetn(resetn),
      .osc_tick(osc_tick),
      .div(system_clock_divider),
      .sys_tick(sys_tick)
   );

   // Control outputs, registered
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrl <= '0;
         clk_sel <= '0;
      end else begin
         // only CPU clock stops in idle
         ctrl.cpu_clk_en <= (next_mode == PMC_RUN);
         ctrl.per_clk_en <= (next_mode != PMC_PDOWN);
         // oscillator and flash off in power-down
         ctrl.osc_run <= (next_mode != PMC_PDOWN);
         ctrl.flash_en <= (next_mode != PMC_PDOWN);
         ctrl.pc_hold <= (next_mode != PMC_RUN);
         // watchdog clear on entry and wake
         ctrl.wdt_clear <= entering | leaving;
         clk_sel.osc_sel <= osc_sel;
         clk_sel.rc_fast <= rc_fast;
         clk_sel.filt_en <= filt_en;
      end
   end

   // Software reset deliberately has no path into the mode logic
   wire unused_ok = soft_reset | irq_taken | clock_config_byte[PMC_FLD_CWDT];
endmodule : pmc_top
`default_nettype wire

// ### core/pmc_pkg.sv
// Package for the power-mode and clock control block.
// Assumes a single 100 MHz bus clock and AXI4-Lite register access.
package pmc_pkg;
   localparam logic [7:0] PMC_OFF_PWR_CTRL = 8'h00;
   localparam logic [7:0] PMC_OFF_CLK_CFG = 8'h04;
   localparam logic [7:0] PMC_OFF_SYS_DIV = 8'h08;
   localparam logic [7:0] PMC_OFF_WAKE_EN = 8'h0c;
   localparam logic [7:0] PMC_OFF_STATUS = 8'h10;
   localparam int PMC_ADDR_W = 8;
   localparam int PMC_BIT_IDLE = 0;
   localparam int PMC_BIT_PDOWN = 1;
   localparam int PMC_FLD_OSC_LO = 0;
   localparam int PMC_FLD_RCFS = 3;
   localparam int PMC_FLD_CKF = 4;
   localparam int PMC_FLD_CWDT = 7;
   localparam logic [7:0] PMC_CLK_CFG_RESET = 8'hff;
   localparam logic [7:0] PMC_SYS_DIV_RESET = 8'h00;
   localparam logic [7:0] PMC_CLK_CFG_MASK = 8'h9b;
   localparam logic [1:0] PMC_OSC_RC = 2'h3;
   localparam logic [1:0] PMC_OSC_XTAL = 2'h1;
   localparam int PMC_WAKE_EXT0 = 0;
   localparam int PMC_WAKE_EXT1 = 1;
   localparam int PMC_WAKE_BOD = 2;
   localparam int PMC_WAKE_WDT = 3;
   localparam int PMC_WAKE_KEY = 4;
   localparam int PMC_WAKE_W = 5;
   localparam int PMC_FILT_LEN = 3;
   localparam logic [1:0] PMC_RESP_OKAY = 2'h0;
   localparam logic [1:0] PMC_RESP_SLVERR = 2'h2;

   typedef enum {PMC_RUN, PMC_IDLE, PMC_PDOWN} pmc_mode_t;

   typedef struct packed {
      logic [1:0] osc_sel;
      logic rc_fast;
      logic filt_en;
   } pmc_clk_sel_t;

   typedef struct packed {
      logic cpu_clk_en;
      logic per_clk_en;
      logic osc_run;
      logic flash_en;
      logic pc_hold;
      logic wdt_clear;
   } pmc_ctrl_t;
endpackage : pmc_pkg

// ### core/pmc_clkdiv.sv
// Oscillator-to-system clock enable divider.
// Assumes the selected oscillator is represented by the bus-clock enable osc_tick.
`timescale 1ns/10ps
`default_nettype none
module pmc_clkdiv #(
   parameter int DIV_W = 8
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic osc_tick,
   input wire logic [DIV_W-1:0] div,
   output logic sys_tick
);
   import pmc_pkg::*;
   logic [DIV_W:0] cnt;
   // Zero passes every oscillator edge, else one tick per 2*(div+1)
   wire [DIV_W:0] limit = {div, 1'b1};
   wire bypass = (div == '0);
   wire wrap = (cnt >= limit);
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt <= '0;
         sys_tick <= 1'b0;
      end else begin
         sys_tick <= osc_tick & (bypass | wrap);
         if (osc_tick) begin
            cnt <= (bypass | wrap) ? '0 : cnt + 1'b1;
         end
      end
   end
endmodule : pmc_clkdiv
`default_nettype wire

// ### bench/pmc_top_properties.sv
// Concurrent checks on the pmc_top ports, bound into every pmc_top.
// Assumes one clock domain with the active-low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module pmc_props (
   input wire logic clk,
   input wire logic resetn,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic instr_done,
   input wire pmc_pkg::pmc_ctrl_t ctrl,
   input wire logic sys_tick,
   input wire logic cpu_restart
);
   import pmc_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   bresp_hold_a:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   rdata_hold_a:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read data dropped early");
   read_answer_a:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   resp_block_a:
      assert property (!s_axi_awready && !s_axi_wready && !s_axi_bvalid |=>
         s_axi_bvalid && s_axi_awready && s_axi_wready)
      else $error("write response not issued");
   mode_after_instr_a:
      assert property ($fell(ctrl.cpu_clk_en) |->
         $past(instr_done) || $past(instr_done, 2) || $past(instr_done, 3))
      else $error("cpu clock stopped without instruction end");
   idle_periph_a:
      assert property ($fell(ctrl.cpu_clk_en) && ctrl.osc_run |->
         ctrl.per_clk_en ##1 ctrl.per_clk_en)
      else $error("peripheral clock stopped in idle");
   pd_freeze_a:
      assert property (!ctrl.osc_run |->
         !ctrl.cpu_clk_en && !ctrl.per_clk_en && !ctrl.flash_en)
      else $error("clock running in power-down");
   pd_no_tick_a:
      assert property (!ctrl.osc_run [*4] |-> !sys_tick)
      else $error("system tick while oscillator stopped");
   wdt_entry_a:
      assert property ($fell(ctrl.cpu_clk_en) |->
         (ctrl.wdt_clear || $past(ctrl.wdt_clear)) or ##1 ctrl.wdt_clear)
      else $error("watchdog not cleared on entry");
   restart_run_a:
      assert property (cpu_restart |=> !cpu_restart ##[0:3] ctrl.cpu_clk_en)
      else $error("restart without running cpu");
   pc_hold_a:
      assert property (ctrl.osc_run |-> ctrl.flash_en && (ctrl.pc_hold != ctrl.cpu_clk_en))
      else $error("program counter hold wrong");

   cover property (ctrl.osc_run && !ctrl.cpu_clk_en);
   cover property (!ctrl.osc_run ##1 ctrl.osc_run);
   cover property (cpu_restart);
endmodule : pmc_props

bind pmc_top pmc_props u_props (
   .clk(clk),
   .resetn(resetn),
   .s_axi_awready(s_axi_awready),
   .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready),
   .instr_done(instr_done),
   .ctrl(ctrl),
   .sys_tick(sys_tick),
   .cpu_restart(cpu_restart)
);
`default_nettype wire

// ### bench/tb_power_mode_clock_control.sv
// Self-checking bench for pmc_top: registers, clock choice, idle, power-down.
// Assumes pmc_pkg, pmc_top and the property checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_power_mode_clock_control;
   import pmc_pkg::*;
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
   $display("ERROR %0t got %0h want %0h", $time, a, e); end end
   logic clk = 1'b0, resetn = 1'b0, irq_taken = 1'b0, irq_pending = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, pls = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp, ext_int_pin = 2'h3;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic rc_osc_pin = 1'b0, crystal_input_pin = 1'b0, keypad_pin = 1'b0, sys_tick, cpu_restart;
   pmc_ctrl_t ctrl;
   pmc_clk_sel_t clk_sel;
   int n_fail = 0, n_checks = 0, ticks = 0, n_wdt = 0, n_rst = 0, w0, t0;
   wire soft_reset = pls[0];
   wire por_reset = pls[1];
   wire pin_reset = pls[2];
   wire bod_reset = pls[3];
   wire wdt_reset = pls[4];
   wire instr_done = pls[5];
   wire bod_event = pls[6];
   wire wdt_event = pls[7];

   pmc_top #(.DIV_W(8)) dut (
      .clk(clk),
      .resetn(resetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .soft_reset(soft_reset),
      .por_reset(por_reset),
      .pin_reset(pin_reset),
      .bod_reset(bod_reset),
      .wdt_reset(wdt_reset),
      .instr_done(instr_done),
      .irq_taken(irq_taken),
      .irq_pending(irq_pending),
      .rc_osc_pin(rc_osc_pin),
      .crystal_input_pin(crystal_input_pin),
      .ext_int_pin(ext_int_pin),
      .bod_event(bod_event),
      .wdt_event(wdt_event),
      .keypad_pin(keypad_pin),
      .ctrl(ctrl),
      .clk_sel(clk_sel),
      .sys_tick(sys_tick),
      .cpu_restart(cpu_restart)
   );

   initial begin
      forever #5 clk = ~clk;
   end

   // Oscillator pins toggle every cycle: one rising edge per two cycles
   always @(posedge clk) begin
      rc_osc_pin <= ~rc_osc_pin;
      crystal_input_pin <= ~crystal_input_pin;
      ticks <= ticks + int'(sys_tick);
      n_wdt <= n_wdt + int'(ctrl.wdt_clear);
      n_rst <= n_rst + int'(cpu_restart);
   end

   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask : step

   task automatic pulse(input int i);
      pls[i] <= 1'b1;
      @(posedge clk);
      pls[i] <= 1'b0;
   endtask : pulse

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int k;
      k = 0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         k++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && k < 50);
      s_axi_bready <= 1'b0;
      `CHK(s_axi_bresp, er)
      if (k >= 50) n_fail++;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, input logic [1:0] er);
      int k;
      k = 0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         k++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && k < 50);
      s_axi_rready <= 1'b0;
      rd = s_axi_rdata;
      `CHK(s_axi_rresp, er)
      if (k >= 50) n_fail++;
   endtask : axi_rd

   // Tick count over 160 cycles against the programmed divider ratio
   task automatic rate(input logic [7:0] cfg, input logic [7:0] dv, input int src);
      int e;
      e = src / ((dv == 8'h00) ? 1 : 2 * (int'(dv) + 1));
      axi_wr(PMC_OFF_CLK_CFG, {24'h0, cfg}, PMC_RESP_OKAY);
      axi_wr(PMC_OFF_SYS_DIV, {24'h0, dv}, PMC_RESP_OKAY);
      axi_rd(PMC_OFF_CLK_CFG, PMC_RESP_OKAY);
      `CHK(rd[7:0], (cfg & PMC_CLK_CFG_MASK) | ~PMC_CLK_CFG_MASK)
      `CHK(clk_sel, {cfg[1:0], cfg[3], cfg[4]})
      step(20);
      t0 = ticks;
      step(160);
      `CHK((ticks - t0) inside {[e - 2:e + 2]}, 1'b1)
   endtask : rate

   task automatic enter(input logic [1:0] req);
      axi_wr(PMC_OFF_PWR_CTRL, {30'h0, req}, PMC_RESP_OKAY);
      step(3);
      `CHK(ctrl.cpu_clk_en, 1'b1)
      pulse(5);
      step(3);
   endtask : enter

   task automatic st(input logic [2:0] e);
      step(8);
      `CHK({ctrl.cpu_clk_en, ctrl.per_clk_en, ctrl.osc_run}, e)
   endtask : st

   task automatic test_done;
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : test_done

   initial begin
      #200000;
      n_fail++;
      test_done();
   end

   initial begin
      step(10);
      resetn <= 1'b1;
      axi_rd(PMC_OFF_CLK_CFG, PMC_RESP_OKAY);
      `CHK(rd[7:0], 8'hff)
      `CHK(clk_sel, 4'hf)
      axi_rd(PMC_OFF_SYS_DIV, PMC_RESP_OKAY);
      `CHK(rd[7:0], 8'h00)
      axi_rd(8'h40, PMC_RESP_SLVERR);
      axi_wr(8'h40, 32'h0, PMC_RESP_SLVERR);
      rate(8'hff, 8'h00, 80);
      rate(8'hf7, 8'h00, 40);
      rate(8'hff, 8'h01, 80);
      rate(8'hff, 8'hff, 80);
      rate(8'h01, 8'h03, 80);
      rate(8'h11, 8'h00, 0);
      rate(8'h00, 8'h00, 80);
      rate(8'h02, 8'h00, 80);
      rate(8'hff, 8'h00, 80);
      axi_wr(PMC_OFF_WAKE_EN, 32'h80, PMC_RESP_OKAY);
      w0 = n_wdt;
      enter(2'h1);
      st(3'h3);
      pulse(0);
      st(3'h3);
      irq_pending <= 1'b1;
      st(3'h7);
      irq_pending <= 1'b0;
      axi_rd(PMC_OFF_PWR_CTRL, PMC_RESP_OKAY);
      `CHK(rd[1:0], 2'h0)
      `CHK(n_wdt - w0 >= 2, 1'b1)
      enter(2'h1);
      pulse(1);
      st(3'h7);
      // Five wake sources over six passes; keypad twice, entering low then high
      for (int i = 0; i < 6; i++) begin
         axi_wr(PMC_OFF_WAKE_EN, 32'h80 | (32'h1 << ((i > 4) ? 4 : i)), PMC_RESP_OKAY);
         enter(2'h3);
         st(3'h0);
         axi_rd(PMC_OFF_STATUS, PMC_RESP_OKAY);
         `CHK(rd[2:1], 2'h2)
         case (i)
            0, 1: ext_int_pin[i] <= 1'b0;
            2: pulse(6);
            3: pulse(7);
            default: keypad_pin <= ~keypad_pin;
         endcase
         st(3'h7);
         ext_int_pin <= 2'h3;
         axi_rd(PMC_OFF_STATUS, PMC_RESP_OKAY);
         `CHK(rd[2:1], 2'h0)
      end
      axi_wr(PMC_OFF_WAKE_EN, 32'h01, PMC_RESP_OKAY);
      enter(2'h2);
      t0 = ticks;
      ext_int_pin <= 2'h2;
      pulse(0);
      st(3'h0);
      `CHK(ticks, t0)
      ext_int_pin <= 2'h3;
      // Global enable set: the same pin event now wakes
      axi_wr(PMC_OFF_WAKE_EN, 32'h81, PMC_RESP_OKAY);
      ext_int_pin <= 2'h2;
      st(3'h7);
      ext_int_pin <= 2'h3;
      for (int r = 1; r < 5; r++) begin
         enter(2'h2);
         w0 = n_rst;
         pulse(r);
         st(3'h7);
         `CHK(n_rst - w0, int'(r <= 2))
      end
      test_done();
   end
endmodule : tb_power_mode_clock_control
`default_nettype wire
